// >>> hdl/bas_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: included by bare name from the package and the design modules
// Notes:   definitions only
`ifndef BAS_REGS_SVH
`define BAS_REGS_SVH

// ---------------------------------------------------------------
// register access
// ---------------------------------------------------------------
`define BAS_ADDR_W        8
`define BAS_DATA_W        16
`define BAS_SUMMARY_OFS   8'h04
`define BAS_REJECT_OFS    8'h03
`define BAS_REJECT_BIT    0

// ---------------------------------------------------------------
// summary register fields
// ---------------------------------------------------------------
`define BAS_TIMEOUT_BIT   15
`define BAS_THERMAL_BIT   14
`define BAS_CAL_BIT       13
`define BAS_NOTICE_BIT    12
`define BAS_DONE_BIT      11
`define BAS_FLAG_HI       15
`define BAS_FLAG_LO       11
`define BAS_FLAG_N        5
`define BAS_FLAG_RST      5'h00
`define BAS_RSVD_RST      11'h000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define BAS_CLK_MHZ        50
`define BAS_NOTICE_BASE_US 1000
`define BAS_NOTICE_BASE_CYC (`BAS_NOTICE_BASE_US * `BAS_CLK_MHZ)
`define BAS_NCFG_W         3

`endif

// >>> hdl/bas_pkg.sv
// Purpose: shared types of the balancing alert status block
// Assumes: bas_regs.svh holds the numbers
// Notes:   every use is written bas_pkg::name
`include "bas_regs.svh"

package bas_pkg;

  // kind of balancing run reported by the balancing engine
  typedef enum logic [1:0]
  {
    BAS_RUN_MANUAL    = 2'h0,
    BAS_RUN_DISCHARGE = 2'h1,
    BAS_RUN_AUTO      = 2'h2,
    BAS_RUN_NONE      = 2'h3
  } bas_run_mode_t;

  // run status from the balancing engine
  typedef struct packed
  {
    logic          active;
    bas_run_mode_t mode;
  } bas_run_t;

  // one-cycle end-of-run events from the balancing engine
  typedef struct packed
  {
    logic timeout;
    logic thermal;
    logic calib;
    logic done_timer;
    logic done_uv;
  } bas_halt_t;

  // register access request
  typedef struct packed
  {
    logic                    wr;
    logic                    rd;
    logic [`BAS_ADDR_W-1:0]  addr;
    logic [`BAS_DATA_W-1:0]  wdata;
  } bas_reg_req_t;

  // progress notice timer states, one-hot
  typedef enum logic [1:0]
  {
    BAS_NTC_OFF   = 2'b01,
    BAS_NTC_COUNT = 2'b10
  } bas_ntc_state_t;

endpackage

// >>> hdl/bas_notice_timer.sv
// Purpose: periodic progress tick during discharge and automated runs
// Assumes: cfg of zero disables; otherwise period is cfg base periods
// Notes:   tick is a one-cycle pulse from a flip-flop
`timescale 1ns/10ps
`include "bas_regs.svh"

module bas_notice_timer
#(
  parameter int unsigned BASE_CYC = `BAS_NOTICE_BASE_CYC
)
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire logic                   run_ok,
  input  wire logic [`BAS_NCFG_W-1:0] cfg,
  output logic                        tick
);

  bas_pkg::bas_ntc_state_t  state_r;
  logic [31:0]              pre_r;
  logic [`BAS_NCFG_W-1:0]   unit_r;
  logic                     tick_r;
  logic                     pre_wrap;
  logic                     unit_wrap;
  logic                     counting;

  assign counting  = (state_r == bas_pkg::BAS_NTC_COUNT) && run_ok && (cfg != 3'h0);
  assign pre_wrap  = (pre_r == (BASE_CYC - 32'h1));
  assign unit_wrap = pre_wrap && ((unit_r + 3'h1) == cfg);
  assign tick      = tick_r;

  // state: a config change to zero or the end of a run stops the timer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_r <= bas_pkg::BAS_NTC_OFF;
    else if (ce)
    begin
      case (state_r)
        bas_pkg::BAS_NTC_OFF:
          if (run_ok && (cfg != 3'h0))
            state_r <= bas_pkg::BAS_NTC_COUNT;
        bas_pkg::BAS_NTC_COUNT:
          if (!run_ok || (cfg == 3'h0))
            state_r <= bas_pkg::BAS_NTC_OFF;
        default:
          state_r <= bas_pkg::BAS_NTC_OFF;
      endcase
    end
  end

  // base prescaler; restarts each run so the first notice is a full period late
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pre_r <= 32'h0;
    else if (ce)
      pre_r <= (!counting || pre_wrap) ? 32'h0 : pre_r + 32'h1;
  end

  // base periods elapsed in the current notice period
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      unit_r <= 3'h0;
    else if (ce)
    begin
      if (!counting || unit_wrap)
        unit_r <= 3'h0;
      else if (pre_wrap)
        unit_r <= unit_r + 3'h1;
    end
  end

  // tick pulse
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tick_r <= 1'b0;
    else if (ce)
      tick_r <= counting && unit_wrap;
  end

endmodule

// >>> hdl/bas_alert_status.sv
// Purpose: latched alerts about balancing runs and rejected protected writes
// Assumes: balancing engine, scan engine and register decoder are outside
// Notes:   all alert flags are set by hardware and cleared by writing zero
`timescale 1ns/10ps
`include "bas_regs.svh"

module bas_alert_status
#(
  parameter int unsigned NOTICE_BASE_CYC = `BAS_NOTICE_BASE_CYC
)
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  input  wire bas_pkg::bas_reg_req_t     reg_req,
  output logic [`BAS_DATA_W-1:0]         reg_rdata,
  input  wire logic                      prot_wr,
  input  wire logic                      scan_active,
  output logic                           prot_wr_accept,
  output logic                           prot_wr_discard,
  input  wire bas_pkg::bas_run_t         run,
  input  wire bas_pkg::bas_halt_t        halt,
  input  wire logic                      balance_timeout_disable,
  input  wire logic                      balance_thermal_enable,
  input  wire logic [`BAS_NCFG_W-1:0]    balance_notice_config,
  output logic [`BAS_DATA_W-1:0]         balancing_alert_summary,
  output logic                           protected_write_reject_alert
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [`BAS_FLAG_N-1:0]  flag_r;
  logic [`BAS_FLAG_N-1:0]  set_vec;
  logic [`BAS_FLAG_N-1:0]  clr_vec;
  logic                    reject_r;
  logic                    reject_set;
  logic                    reject_clr;
  logic                    accept_r;
  logic                    discard_r;
  logic [`BAS_DATA_W-1:0]  rdata_r;
  logic [`BAS_DATA_W-1:0]  rdata_nxt;
  logic [`BAS_DATA_W-1:0]  summary_view;
  logic                    busy;
  logic                    sum_wr;
  logic                    rej_wr;
  logic                    any_kind;
  logic                    dis_or_auto;
  logic                    notice_tick;

  // ---------------------------------------------------------------
  // decode of run kind and register writes
  // ---------------------------------------------------------------
  // a halt event only counts while the engine still reports its run kind
  assign any_kind    = run.active && (run.mode != bas_pkg::BAS_RUN_NONE);
  assign dis_or_auto = run.active && ((run.mode == bas_pkg::BAS_RUN_DISCHARGE)
                                   || (run.mode == bas_pkg::BAS_RUN_AUTO));
  assign busy        = scan_active || run.active;
  assign sum_wr      = reg_req.wr && (reg_req.addr == `BAS_SUMMARY_OFS);
  assign rej_wr      = reg_req.wr && (reg_req.addr == `BAS_REJECT_OFS);

  // ---------------------------------------------------------------
  // progress notice timer
  // ---------------------------------------------------------------
  // manual runs get no progress notice, so only discharge and automated qualify
  bas_notice_timer
  #(
    .BASE_CYC (NOTICE_BASE_CYC)
  )
  u_notice
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .run_ok  (dis_or_auto),
    .cfg     (balance_notice_config),
    .tick    (notice_tick)
  );

  // ---------------------------------------------------------------
  // alert set and clear terms
  // ---------------------------------------------------------------
  // index 0 is bit 11, index 4 is bit 15
  always_comb
  begin
    set_vec    = 5'h00;
    set_vec[4] = halt.timeout && !balance_timeout_disable && dis_or_auto;
    set_vec[3] = halt.thermal && balance_thermal_enable && any_kind;
    set_vec[2] = halt.calib && dis_or_auto;
    set_vec[1] = notice_tick;
    set_vec[0] = (halt.done_timer || halt.done_uv) && any_kind;
  end

  // a zero in the written data clears; a one is ignored
  assign clr_vec = sum_wr ? ~reg_req.wdata[`BAS_FLAG_HI:`BAS_FLAG_LO] : 5'h00;

  // ---------------------------------------------------------------
  // alert flags
  // ---------------------------------------------------------------
  // set wins over a clear in the same cycle so no event is lost; the block
  // does not check that a run has ended before a clear, that is software's job
  generate
    for (genvar i = 0; i < `BAS_FLAG_N; i++)
    begin : g_flag
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          flag_r[i] <= 1'b0;
        else if (ce)
        begin
          if (set_vec[i])
            flag_r[i] <= 1'b1;
          else if (clr_vec[i])
            flag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // protected write screening
  // ---------------------------------------------------------------
  assign reject_set = prot_wr && busy;
  assign reject_clr = rej_wr && !reg_req.wdata[`BAS_REJECT_BIT];

  // reject flag, set wins over a clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reject_r <= 1'b0;
    else if (ce)
    begin
      if (reject_set)
        reject_r <= 1'b1;
      else if (reject_clr)
        reject_r <= 1'b0;
    end
  end

  // commit or discard strobe to the protected register, one cycle late;
  // the register must update only on accept, never on the raw write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      accept_r  <= 1'b0;
      discard_r <= 1'b0;
    end
    else if (ce)
    begin
      accept_r  <= prot_wr && !busy;
      discard_r <= prot_wr && busy;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  assign summary_view = {flag_r, `BAS_RSVD_RST};

  // unmapped offsets read as zero; reads have no side effect
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `BAS_SUMMARY_OFS: rdata_nxt = summary_view;
        `BAS_REJECT_OFS:  rdata_nxt = {15'h0000, reject_r};
        default:          rdata_nxt = 16'h0000;
      endcase
    end
  end

  // read data register, holds until the next read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_r <= 16'h0000;
    else if (ce)
      rdata_r <= rdata_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata                    = rdata_r;
  assign prot_wr_accept               = accept_r;
  assign prot_wr_discard              = discard_r;
  assign balancing_alert_summary      = summary_view;
  assign protected_write_reject_alert = reject_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_busy_write;
    ce && prot_wr && busy;
  endsequence

  sequence s_free_write;
    ce && prot_wr && !busy;
  endsequence

  sequence s_zero_write;
    ce && sum_wr && (reg_req.wdata[15:11] == 5'h00) && (set_vec == 5'h00);
  endsequence

  sequence s_ones_write;
    ce && sum_wr && (reg_req.wdata[15:11] == 5'h1F);
  endsequence

  chk_reject_sets: assert property (
    s_busy_write |=> reject_r && protected_write_reject_alert)
    else $error("reject flag not set by busy protected write");

  chk_discard_busy: assert property (
    s_busy_write |=> prot_wr_discard && !prot_wr_accept)
    else $error("busy protected write not discarded");

  chk_accept_free: assert property (
    s_free_write |=> prot_wr_accept && !prot_wr_discard)
    else $error("idle protected write not accepted");

  chk_zero_clears: assert property (
    s_zero_write |=> (flag_r == 5'h00))
    else $error("zero write did not clear alert flags");

  chk_one_keeps: assert property (
    s_ones_write |=> ((flag_r & $past(flag_r)) == $past(flag_r)))
    else $error("one write changed alert flags");

  chk_read_layout: assert property (
    ce && reg_req.rd && (reg_req.addr == `BAS_SUMMARY_OFS)
    |=> (reg_rdata[10:0] == 11'h000) && (reg_rdata[15:11] == $past(flag_r)))
    else $error("summary read data wrong");

  chk_timeout_gated: assert property (
    ce && balance_timeout_disable && !flag_r[4] |=> !flag_r[4])
    else $error("timeout alert set while disabled");

  chk_timeout_sets: assert property (
    ce && halt.timeout && !balance_timeout_disable && dis_or_auto |=> flag_r[4])
    else $error("timeout alert missed");

  chk_thermal_gated: assert property (
    ce && !balance_thermal_enable && !flag_r[3] |=> !flag_r[3])
    else $error("thermal alert set while not enabled");

  chk_cal_manual: assert property (
    ce && (run.mode == bas_pkg::BAS_RUN_MANUAL) && !flag_r[2] |=> !flag_r[2])
    else $error("calibration alert set in manual run");

  chk_notice_sets: assert property (
    ce && notice_tick |=> flag_r[1])
    else $error("progress notice not latched");

  chk_done_sets: assert property (
    ce && (halt.done_timer || halt.done_uv) && any_kind |=> flag_r[0] ##0 flag_r[0])
    else $error("completion alert missed");

  chk_flags_steady: assert property (
    ce && (set_vec == 5'h00) && !sum_wr |=> $stable(flag_r))
    else $error("alert flags moved without cause");

  chk_thermal_sets: assert property (
    ce && halt.thermal && balance_thermal_enable && any_kind |=> flag_r[3])
    else $error("thermal alert missed");

  chk_cal_sets: assert property (
    ce && halt.calib && dis_or_auto |=> flag_r[2])
    else $error("calibration alert missed");

  chk_reject_clears: assert property (
    ce && rej_wr && !reg_req.wdata[`BAS_REJECT_BIT] && !(prot_wr && busy) |=> !reject_r)
    else $error("zero write did not clear reject flag");

  chk_reject_steady: assert property (
    ce && !(prot_wr && busy) && !rej_wr |=> $stable(reject_r))
    else $error("reject flag moved without cause");

  chk_strobes_idle: assert property (
    ce && !prot_wr |=> !prot_wr_accept && !prot_wr_discard)
    else $error("protected write strobe without a write");

  chk_notice_off: assert property (
    ce && (balance_notice_config == 3'h0) |=> !notice_tick)
    else $error("progress notice while disabled");

endmodule

// >>> testbench/bas_alert_status_tb.sv
// Purpose: self-checking bench for the balancing alert status block
// Assumes: registers reached by the one-cycle strobe port, inputs driven at negedge
// Notes:   random stimulus from a fixed seed with corner cases mixed in
`timescale 1ns/10ps
`include "bas_regs.svh"

module testbench;
  localparam int unsigned BASE = 4;  // short notice base period keeps the run brief

  logic                   clk;
  logic                   sys_rst;
  logic                   ce;
  bas_pkg::bas_reg_req_t  req;
  logic [`BAS_DATA_W-1:0] reg_rdata;
  logic                   prot_wr;
  logic                   scan_active;
  logic                   acc;
  logic                   dis;
  bas_pkg::bas_run_t      run;
  bas_pkg::bas_halt_t     halt;
  logic                   tod;
  logic                   ten;
  logic [`BAS_NCFG_W-1:0] ncfg;
  logic [`BAS_DATA_W-1:0] summary;
  logic                   rej;
  int                     error_cnt;
  int                     compares;
  int                     seed;
  int                     cnt;
  int                     n;
  logic [4:0]             flags;  // expected summary flags
  logic [15:0]            wd;
  logic                   rj;
  logic                   busy;
  logic [31:0]            rnd;

  bas_alert_status #(.NOTICE_BASE_CYC(BASE)) dut_u
  (
    .clk                          (clk),
    .sys_rst                      (sys_rst),
    .ce                           (ce),
    .reg_req                      (req),
    .reg_rdata                    (reg_rdata),
    .prot_wr                      (prot_wr),
    .scan_active                  (scan_active),
    .prot_wr_accept               (acc),
    .prot_wr_discard              (dis),
    .run                          (run),
    .halt                         (halt),
    .balance_timeout_disable      (tod),
    .balance_thermal_enable       (ten),
    .balance_notice_config        (ncfg),
    .balancing_alert_summary      (summary),
    .protected_write_reject_alert (rej)
  );

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // a hang anywhere ends the run as a failure
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // compare, access and expectation helpers
  // ---------------------------------------------------------------
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // strobe is lowered and one edge left idle so no signal is set twice at once
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    cmp16(what, exp, reg_rdata);
    @(negedge clk);
  endtask

  // which flag a halt kind sets for a given run mode and enables
  function automatic logic [4:0] halt_exp(input int k, input logic [1:0] m, input logic d,
                                          input logic e);
    logic dch;
    dch = (m == 2'h1) || (m == 2'h2);
    case (k)
      0: halt_exp = (!d && dch) ? 5'h10 : 5'h00;
      1: halt_exp = (e && m != 2'h3) ? 5'h08 : 5'h00;
      2: halt_exp = dch ? 5'h04 : 5'h00;
      default: halt_exp = (m != 2'h3) ? 5'h01 : 5'h00;
    endcase
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    req = '0;
    prot_wr = 1'b0;
    scan_active = 1'b0;
    run = '{1'b0, bas_pkg::BAS_RUN_NONE};
    halt = '0;
    tod = 1'b0;
    ten = 1'b1;
    ncfg = '0;
    error_cnt = 0;
    compares = 0;
    seed = 32'h42D0;
    flags = 5'h00;
    rj = 1'b0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    cmp16("summary after reset", 16'h0000, summary);
    reg_rd(8'h04, 16'h0000, "summary read");
    reg_rd(8'h03, 16'h0000, "reject read");
    reg_rd(8'h10, 16'h0000, "unmapped read");
    $display("test reset done");

    // every halt kind under every run mode, enables drawn at random
    for (int i = 0; i < 40; i++)
    begin
      rnd = $random(seed);
      tod = rnd[0];
      ten = rnd[1];
      run = '{1'b1, bas_pkg::bas_run_mode_t'((i / 5) % 4)};
      @(negedge clk);
      if (i % 5 == 0)
        cmp16("summary while running", 16'h0000, summary);
      halt = 5'h10 >> (i % 5);
      @(negedge clk);
      halt = '0;
      flags = flags | halt_exp(i % 5, run.mode, tod, ten);
      cmp16("summary after halt", {flags, 11'h000}, summary);
      if (i % 5 == 4)
      begin
        run.active = 1'b0;
        reg_rd(8'h04, {flags, 11'h000}, "summary read");
        reg_wr(8'h04, 16'hFFFF);
        cmp16("summary after ones", {flags, 11'h000}, summary);
        rnd = $random(seed);
        wd = rnd[15:0];
        flags = flags & wd[15:11];
        reg_wr(8'h04, wd);
        cmp16("summary after partial clear", {flags, 11'h000}, summary);
        reg_wr(8'h04, 16'h0000);
        flags = 5'h00;
        cmp16("summary after clear", 16'h0000, summary);
      end
    end
    $display("test halt kinds done");

    // a frozen block takes no event
    ce = 1'b0;
    run = '{1'b1, bas_pkg::BAS_RUN_AUTO};
    halt = 5'h04;
    @(negedge clk);
    halt = '0;
    ce = 1'b1;
    run.active = 1'b0;
    @(negedge clk);
    cmp16("summary with ce low", 16'h0000, summary);
    $display("test clock enable done");

    // corner: a zero write in the cycle of a halt event loses to the event
    run = '{1'b1, bas_pkg::BAS_RUN_AUTO};
    halt = 5'h04;
    req.addr = 8'h04;
    req.wdata = 16'h0000;
    req.wr = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
    halt = '0;
    run.active = 1'b0;
    cmp16("summary set over clear", 16'h2000, summary);
    @(negedge clk);
    reg_wr(8'h04, 16'h0000);
    cmp16("summary after late clear", 16'h0000, summary);
    $display("test set over clear done");

    // protected writes against idle, scan, run and both
    for (int c = 0; c < 4; c++)
    begin
      scan_active = c[0];
      run = '{c[1], bas_pkg::BAS_RUN_DISCHARGE};
      busy = (c != 0);
      prot_wr = 1'b1;
      @(negedge clk);
      prot_wr = 1'b0;
      rj = rj | busy;
      cmp1("discard", busy, dis);
      cmp1("accept", !busy, acc);
      cmp1("reject alert", rj, rej);
      @(negedge clk);
      cmp1("discard after pulse", 1'b0, dis);
    end
    scan_active = 1'b0;
    run.active = 1'b0;
    reg_rd(8'h03, 16'h0001, "reject read");
    reg_wr(8'h03, 16'hFFFF);
    cmp1("reject after one", 1'b1, rej);
    reg_wr(8'h03, 16'h0000);
    cmp1("reject after zero", 1'b0, rej);
    $display("test protected write done");

    // progress notice only for discharge and automated runs
    for (int m = 0; m < 3; m++)
    begin
      n = ($unsigned($random(seed)) % 3) + 1;
      ncfg = n[2:0];
      run = '{1'b1, bas_pkg::bas_run_mode_t'(m)};
      cnt = 0;
      while (summary[`BAS_NOTICE_BIT] !== 1'b1 && cnt < n * BASE + 6)
      begin
        @(negedge clk);
        cnt++;
      end
      cmp1("notice set", m != 0, summary[`BAS_NOTICE_BIT]);
      cmp1("notice delay", (m == 0) || (cnt >= n * BASE && cnt <= n * BASE + 3), 1'b1);
      if (m != 0 && cnt == n * BASE + 6)
        wrap_up();
      run.active = 1'b0;
      ncfg = '0;
      reg_wr(8'h04, 16'h0000);
      cmp16("summary after notice clear", 16'h0000, summary);
    end
    $display("test notice done");
    wrap_up();
  end
endmodule
